// ---- logic/cmoh_pkg.sv ----
// Shared constants and types of the CAN message object handler.
// Assumes a single 100 MHz module clock and one set of interface registers.
package cmoh_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CMOH_NUM_OBJ = 32;
  localparam int CMOH_ID_W = 29;

  // ----------------------------------------------------------------
  // Arbitration word: valid, extended, direction, identifier.
  // A standard identifier sits in id bits 28:18 (bits 12:2 of word two).
  // ----------------------------------------------------------------
  localparam int CMOH_ARB_VAL = 31;
  localparam int CMOH_ARB_XTD = 30;
  localparam int CMOH_ARB_DIR = 29;
  localparam int CMOH_STD_LO = 18;
  localparam logic [28:0] CMOH_STD_CARE = 29'h1FFC0000;

  // ----------------------------------------------------------------
  // Mask word: extended-only flag, mask bits in 28:0.
  // ----------------------------------------------------------------
  localparam int CMOH_MSK_XTD = 31;

  // ----------------------------------------------------------------
  // Message control word.
  // ----------------------------------------------------------------
  localparam int CMOH_CTL_FRESH_CONTENT_FLAG = 15;
  localparam int CMOH_CTL_LOST = 14;
  localparam int CMOH_CTL_IPND = 13;
  localparam int CMOH_CTL_USE_ACCEPTANCE_MASK = 12;
  localparam int CMOH_CTL_TRANSMIT_IRQ_ENABLE = 11;
  localparam int CMOH_CTL_RECEIVE_IRQ_ENABLE = 10;
  localparam int CMOH_CTL_REMOTE_ANSWER_ENABLE = 9;
  localparam int CMOH_CTL_TXRQ = 8;
  localparam int CMOH_CTL_EOB = 7;

  // ----------------------------------------------------------------
  // Message object as held in the message RAM.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] arb;
    logic [31:0] mask;
    logic [15:0] ctrl;
    logic [63:0] data;
  } cmoh_obj_t;

  localparam cmoh_obj_t CMOH_OBJ_RST = '0;

  // Handler sequencing states.
  typedef enum logic [1:0] {CMOH_IDLE, CMOH_SCAN, CMOH_WAIT_END} cmoh_state_t;

endpackage : cmoh_pkg

// ---- logic/cmoh_handler.sv ----
// Message object handler: message RAM, acceptance scan, frame store,
// transmit selection and interface-register transfers.
// Assumes the protocol controller runs on the same clock and that
// software holds command fields stable from request to done.

// How it works
// - Standard identifiers use id bits 28:18 only; lower bits are ignored.
// - Successful transmission sets the pending flag when transmit irq enabled.
// - Matching remote frame with remote answer enabled raises send request.
// - Acceptance mask selects compared bits; extended-only flag demands the object's id type.
// - Data may be rewritten any time without clearing valid or request.
// - Data-only write updates data, fresh flag and send request together.
// - Renewed request survives running transmission; fresh clears at next start.
// - Complete received header starts the message RAM scan.
// - Scan runs from object zero upward, stopping at first match or end.
// - Stored data frame writes data, full identifier and length.
// - Storing a data frame sets the fresh flag; software clears it.
// - Storing a data frame over unread fresh data sets the overrun flag.
// - Stored data frame sets pending flag when receive irq enabled.
// - Remote frame on answering transmit object sets request, nothing else.
// - Remote frame on non-answering unmasked transmit object is silently dropped.
// - Masked non-answering object stores header, sets fresh, clears request.
// - Lowest object number among pending requests transmits first.
module cmoh_handler import cmoh_pkg::*; #(
  parameter int NUM_OBJ = CMOH_NUM_OBJ,
  localparam int IW = $clog2(NUM_OBJ)
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Interface-register transfer command.
  input wire logic cmd_req,
  input wire logic [IW-1:0] cmd_obj,
  input wire logic cm_write,
  input wire logic cm_arb,
  input wire logic cm_mask,
  input wire logic cm_ctrl,
  input wire logic cm_clr_irq,
  input wire logic cm_fresh,
  input wire logic cm_data_low,
  input wire logic cm_data_high,
  // Interface-register contents written by software.
  input wire logic [31:0] sw_arb,
  input wire logic [31:0] sw_mask,
  input wire logic [15:0] sw_ctrl,
  input wire logic [63:0] sw_data,
  // Interface-register contents read back from the message RAM.
  output logic [31:0] rd_arb_q,
  output logic [31:0] rd_mask_q,
  output logic [15:0] rd_ctrl_q,
  output logic [63:0] rd_data_q,
  output logic cmd_done_q,
  output logic busy_q,
  // Receive shift register.
  input wire logic rx_hdr_valid,
  input wire logic [CMOH_ID_W-1:0] rx_id,
  input wire logic rx_xtd,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic rx_end_ok,
  input wire logic [63:0] rx_data,
  // Transmit shift register.
  input wire logic tx_ready,
  input wire logic tx_ok,
  input wire logic tx_fail,
  output logic tx_load_q,
  output logic [IW-1:0] tx_obj_q,
  output logic [CMOH_ID_W-1:0] tx_id_q,
  output logic tx_xtd_q,
  output logic tx_rtr_q,
  output logic [3:0] tx_dlc_q,
  output logic [63:0] tx_data_q,
  // Per-object status.
  output logic [NUM_OBJ-1:0] irq_pending_q,
  output logic [NUM_OBJ-1:0] fresh_q
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_OBJ < 2 || NUM_OBJ > 64) begin : g_bad_size
    $error("cmoh_handler: NUM_OBJ must lie between 2 and 64");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cmoh_obj_t obj_q [NUM_OBJ];
  cmoh_obj_t obj_d [NUM_OBJ];
  cmoh_state_t state_q, state_d;
  logic [IW-1:0] idx_q, idx_d, match_q, match_d, tx_obj_d;
  logic [CMOH_ID_W-1:0] rxh_id_q, rxh_id_d, tx_id_d;
  logic rxh_xtd_q, rxh_xtd_d, rxh_rtr_q, rxh_rtr_d;
  logic [3:0] rxh_dlc_q, rxh_dlc_d, tx_dlc_d;
  logic cmd_pend_q, cmd_pend_d, cmd_done_d, busy_d;
  logic tx_busy_q, tx_busy_d, renew_q, renew_d;
  logic tx_load_d, tx_xtd_d, tx_rtr_d;
  logic [63:0] tx_data_d, rd_data_d;
  logic [31:0] rd_arb_d, rd_mask_d;
  logic [15:0] rd_ctrl_d;
  logic [NUM_OBJ-1:0] irq_pending_d, fresh_d;
  logic scan_hit, ram_used, cmd_go, tx_any;
  logic [IW-1:0] tx_sel;
  logic [CMOH_ID_W-1:0] care;
  logic xtd_ok;
  cmoh_obj_t o;

  // Next-state logic. Only one RAM access (scan step, store or command)
  // happens per cycle, so software never sees a half-written object.
  always_comb begin
    obj_d = obj_q;
    state_d = state_q;
    idx_d = idx_q;
    match_d = match_q;
    rxh_id_d = rxh_id_q;
    rxh_xtd_d = rxh_xtd_q;
    rxh_rtr_d = rxh_rtr_q;
    rxh_dlc_d = rxh_dlc_q;
    cmd_pend_d = cmd_pend_q | cmd_req;
    cmd_done_d = 1'b0;
    tx_busy_d = tx_busy_q;
    renew_d = renew_q;
    tx_load_d = 1'b0;
    tx_obj_d = tx_obj_q;
    tx_id_d = tx_id_q;
    tx_xtd_d = tx_xtd_q;
    tx_rtr_d = tx_rtr_q;
    tx_dlc_d = tx_dlc_q;
    tx_data_d = tx_data_q;
    rd_arb_d = rd_arb_q;
    rd_mask_d = rd_mask_q;
    rd_ctrl_d = rd_ctrl_q;
    rd_data_d = rd_data_q;
    ram_used = 1'b0;
    scan_hit = 1'b0;
    o = obj_q[idx_q];
    // Acceptance compare of the object under the scan pointer.
    care = o.ctrl[CMOH_CTL_USE_ACCEPTANCE_MASK] ? o.mask[28:0] : '1;
    if (!rxh_xtd_q) begin
      care = care & CMOH_STD_CARE;
    end
    xtd_ok = (o.ctrl[CMOH_CTL_USE_ACCEPTANCE_MASK] && !o.mask[CMOH_MSK_XTD]) ||
             (o.arb[CMOH_ARB_XTD] == rxh_xtd_q);
    if (state_q == CMOH_SCAN) begin
      scan_hit = o.arb[CMOH_ARB_VAL] && (o.arb[CMOH_ARB_DIR] == rxh_rtr_q) && xtd_ok &&
                 (((o.arb[28:0] ^ rxh_id_q) & care) == '0);
    end
    // A fresh header always restarts the scan, even mid-way.
    if (rx_hdr_valid) begin
      rxh_id_d = rx_id;
      rxh_xtd_d = rx_xtd;
      rxh_rtr_d = rx_rtr;
      rxh_dlc_d = rx_dlc;
      state_d = CMOH_SCAN;
      idx_d = '0;
    end else begin
      unique case (state_q)
        CMOH_IDLE: begin
        end
        CMOH_SCAN: begin
          ram_used = 1'b1;
          if (scan_hit && rxh_rtr_q) begin
            state_d = CMOH_IDLE;
            if (o.ctrl[CMOH_CTL_REMOTE_ANSWER_ENABLE]) begin
              o.ctrl[CMOH_CTL_TXRQ] = 1'b1;
              // A request for the object on the bus must outlive its end pulse.
              if (tx_busy_q && tx_obj_q == idx_q) begin
                renew_d = 1'b1;
              end
            end else if (o.ctrl[CMOH_CTL_USE_ACCEPTANCE_MASK]) begin
              o.ctrl[CMOH_CTL_TXRQ] = 1'b0;
              o.arb[28:0] = rxh_id_q;
              o.arb[CMOH_ARB_XTD] = rxh_xtd_q;
              o.ctrl[3:0] = rxh_dlc_q;
              o.ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] = 1'b1;
            end
            // Otherwise the frame is dropped without trace.
            obj_d[idx_q] = o;
          end else if (scan_hit) begin
            match_d = idx_q;
            state_d = CMOH_WAIT_END;
          end else if (idx_q == IW'(NUM_OBJ - 1)) begin
            state_d = CMOH_IDLE;
          end else begin
            idx_d = idx_q + 1'b1;
          end
        end
        CMOH_WAIT_END: begin
          if (rx_end_ok) begin
            ram_used = 1'b1;
            state_d = CMOH_IDLE;
            o = obj_q[match_q];
            o.ctrl[CMOH_CTL_LOST] = o.ctrl[CMOH_CTL_LOST] | o.ctrl[CMOH_CTL_FRESH_CONTENT_FLAG];
            o.ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] = 1'b1;
            o.ctrl[CMOH_CTL_IPND] = o.ctrl[CMOH_CTL_IPND] | o.ctrl[CMOH_CTL_RECEIVE_IRQ_ENABLE];
            o.ctrl[CMOH_CTL_TXRQ] = 1'b0;
            o.arb[28:0] = rxh_id_q;
            o.arb[CMOH_ARB_XTD] = rxh_xtd_q;
            o.ctrl[3:0] = rxh_dlc_q;
            o.data = rx_data;
            obj_d[match_q] = o;
          end
        end
        default: state_d = CMOH_IDLE;
      endcase
    end
    // Interface-register transfer waits while the RAM is busy.
    cmd_go = cmd_pend_d && !ram_used;
    if (cmd_go) begin
      o = obj_d[cmd_obj];
      cmd_pend_d = 1'b0;
      cmd_done_d = 1'b1;
      if (cm_write) begin
        if (cm_arb) o.arb = sw_arb;
        if (cm_mask) o.mask = sw_mask;
        if (cm_ctrl) o.ctrl = sw_ctrl;
        if (cm_data_low) o.data[31:0] = sw_data[31:0];
        if (cm_data_high) o.data[63:32] = sw_data[63:32];
        if (cm_fresh) begin
          o.ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] = 1'b1;
          o.ctrl[CMOH_CTL_TXRQ] = 1'b1;
          if (tx_busy_q && tx_obj_q == cmd_obj) begin
            renew_d = 1'b1;
          end
        end
      end else begin
        rd_arb_d = o.arb;
        rd_mask_d = o.mask;
        rd_ctrl_d = o.ctrl;
        rd_data_d = o.data;
        if (cm_clr_irq) o.ctrl[CMOH_CTL_IPND] = 1'b0;
        if (cm_fresh) o.ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] = 1'b0;
      end
      obj_d[cmd_obj] = o;
    end
    // Lowest pending object number wins, whatever its identifier.
    tx_any = 1'b0;
    tx_sel = '0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (obj_q[i].arb[CMOH_ARB_VAL] && obj_q[i].ctrl[CMOH_CTL_TXRQ]) begin
        tx_any = 1'b1;
        tx_sel = IW'(i);
      end
    end
    // Loading is held off during any RAM transfer so the shift register
    // never picks up an object that is being rewritten.
    if (tx_any && tx_ready && !tx_busy_q && !ram_used && !cmd_go) begin
      o = obj_q[tx_sel];
      tx_load_d = 1'b1;
      tx_busy_d = 1'b1;
      renew_d = 1'b0;
      tx_obj_d = tx_sel;
      tx_id_d = o.arb[28:0];
      tx_xtd_d = o.arb[CMOH_ARB_XTD];
      tx_rtr_d = !o.arb[CMOH_ARB_DIR];
      tx_dlc_d = o.ctrl[3:0];
      tx_data_d = o.data;
      obj_d[tx_sel].ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] = 1'b0;
    end
    // Transmission outcome is applied last so its sets win over clears.
    if (tx_busy_q && tx_ok) begin
      tx_busy_d = 1'b0;
      // A renewal seen up to this cycle keeps the request for one more send.
      if (!renew_d) begin
        obj_d[tx_obj_q].ctrl[CMOH_CTL_TXRQ] = 1'b0;
      end
      renew_d = 1'b0;
      if (obj_d[tx_obj_q].ctrl[CMOH_CTL_TRANSMIT_IRQ_ENABLE]) begin
        obj_d[tx_obj_q].ctrl[CMOH_CTL_IPND] = 1'b1;
      end
    end else if (tx_busy_q && tx_fail) begin
      tx_busy_d = 1'b0; // Request stays, so the object is retried.
    end
    for (int i = 0; i < NUM_OBJ; i++) begin
      irq_pending_d[i] = obj_d[i].ctrl[CMOH_CTL_IPND];
      fresh_d[i] = obj_d[i].ctrl[CMOH_CTL_FRESH_CONTENT_FLAG];
    end
    busy_d = (state_d != CMOH_IDLE) || cmd_pend_d;
  end

  // Registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        obj_q[i] <= CMOH_OBJ_RST;
      end
      state_q <= CMOH_IDLE;
      idx_q <= '0;
      match_q <= '0;
      rxh_id_q <= '0;
      rxh_xtd_q <= 1'b0;
      rxh_rtr_q <= 1'b0;
      rxh_dlc_q <= '0;
      cmd_pend_q <= 1'b0;
      cmd_done_q <= 1'b0;
      busy_q <= 1'b0;
      tx_busy_q <= 1'b0;
      renew_q <= 1'b0;
      tx_load_q <= 1'b0;
      tx_obj_q <= '0;
      tx_id_q <= '0;
      tx_xtd_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      tx_dlc_q <= '0;
      tx_data_q <= '0;
      rd_arb_q <= '0;
      rd_mask_q <= '0;
      rd_ctrl_q <= '0;
      rd_data_q <= '0;
      irq_pending_q <= '0;
      fresh_q <= '0;
    end else begin
      obj_q <= obj_d;
      state_q <= state_d;
      idx_q <= idx_d;
      match_q <= match_d;
      rxh_id_q <= rxh_id_d;
      rxh_xtd_q <= rxh_xtd_d;
      rxh_rtr_q <= rxh_rtr_d;
      rxh_dlc_q <= rxh_dlc_d;
      cmd_pend_q <= cmd_pend_d;
      cmd_done_q <= cmd_done_d;
      busy_q <= busy_d;
      tx_busy_q <= tx_busy_d;
      renew_q <= renew_d;
      tx_load_q <= tx_load_d;
      tx_obj_q <= tx_obj_d;
      tx_id_q <= tx_id_d;
      tx_xtd_q <= tx_xtd_d;
      tx_rtr_q <= tx_rtr_d;
      tx_dlc_q <= tx_dlc_d;
      tx_data_q <= tx_data_d;
      rd_arb_q <= rd_arb_d;
      rd_mask_q <= rd_mask_d;
      rd_ctrl_q <= rd_ctrl_d;
      rd_data_q <= rd_data_d;
      irq_pending_q <= irq_pending_d;
      fresh_q <= fresh_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_scan_start: assert property (rx_hdr_valid |=> state_q == CMOH_SCAN && idx_q == '0)
    else $error("scan did not start after header");
  a_scan_bounded: assert property ($rose(state_q == CMOH_SCAN) |-> ##[1:65] state_q != CMOH_SCAN
    || rx_hdr_valid)
    else $error("scan ran past the end of the message RAM");
  a_store_fresh: assert property (state_q == CMOH_WAIT_END && rx_end_ok && !rx_hdr_valid
    |=> fresh_q[$past(match_q)])
    else $error("stored frame did not set fresh flag");
  a_store_lost: assert property (state_q == CMOH_WAIT_END && rx_end_ok && !rx_hdr_valid &&
    obj_q[match_q].ctrl[CMOH_CTL_FRESH_CONTENT_FLAG] |=> obj_q[$past(match_q)].ctrl[CMOH_CTL_LOST])
    else $error("overwrite of unread data not flagged");
  a_store_irq: assert property (state_q == CMOH_WAIT_END && rx_end_ok && !rx_hdr_valid &&
    obj_q[match_q].ctrl[CMOH_CTL_RECEIVE_IRQ_ENABLE] |=> irq_pending_q[$past(match_q)])
    else $error("receive pending flag missing");
  a_tx_irq: assert property (tx_busy_q && tx_ok && obj_q[tx_obj_q].ctrl[CMOH_CTL_TRANSMIT_IRQ_ENABLE]
    |=> irq_pending_q[$past(tx_obj_q)])
    else $error("transmit pending flag missing");
  a_renew_keeps: assert property (tx_busy_q && tx_ok && renew_q
    |=> obj_q[$past(tx_obj_q)].ctrl[CMOH_CTL_TXRQ])
    else $error("renewed request lost at transmission end");
  a_load_clears: assert property (tx_load_q |-> !fresh_q[tx_obj_q] && tx_busy_q)
    else $error("fresh flag not cleared at transmission start");
  a_remote_answer: assert property (scan_hit && rxh_rtr_q && !rx_hdr_valid &&
    obj_q[idx_q].ctrl[CMOH_CTL_REMOTE_ANSWER_ENABLE] |=> obj_q[$past(idx_q)].ctrl[CMOH_CTL_TXRQ])
    else $error("remote frame did not raise send request");
  a_cmd_serial: assert property (cmd_done_q |-> $past(state_q) != CMOH_SCAN
    || $past(rx_hdr_valid))
    else $error("transfer overlapped a scan step");

  c_data_store: cover property (state_q == CMOH_WAIT_END && rx_end_ok);
  c_remote_hit: cover property (scan_hit && rxh_rtr_q);
  c_tx_done: cover property (tx_busy_q && tx_ok);
  c_renew: cover property (renew_q && tx_ok);

endmodule : cmoh_handler

// ---- dv/cmoh_proto_model.sv ----
// Protocol controller model seen by the handler's transmit shift register port.
// Assumes the bench drives hold and fail_next shortly after a rising clock edge.
module cmoh_proto_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Controls from the bench.
  input wire logic hold,
  input wire logic fail_next,
  // Transmit shift register handshake.
  input wire logic tx_load_q,
  output logic tx_ready,
  output logic tx_ok,
  output logic tx_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  logic act_q;
  logic fail_q;
  // --------------------------------------------------------------
  // Frame on the bus
  // --------------------------------------------------------------
  // A frame takes a random 4 to 8 cycles, so both prompt and slow ends occur.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_q <= 1'b0;
      fail_q <= 1'b0;
      cnt_q <= 0;
      tx_ok <= 1'b0;
      tx_fail <= 1'b0;
    end else begin
      tx_ok <= 1'b0;
      tx_fail <= 1'b0;
      if (tx_load_q) begin
        act_q <= 1'b1;
        fail_q <= fail_next;
        cnt_q <= 3 + $urandom_range(4, 0);
      end else if (act_q && cnt_q == 0) begin
        act_q <= 1'b0;
        tx_ok <= !fail_q;
        tx_fail <= fail_q;
      end else if (act_q) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
  // The register is busy from the load until the cycle after the end pulse.
  assign tx_ready = !act_q && !hold && !tx_load_q && !tx_ok && !tx_fail;
endmodule : cmoh_proto_model

// ---- dv/can_message_object_handler_tb_top.sv ----
// Self-checking bench of the message object handler against a flag and queue model.
// Assumes cmoh_proto_model answers transmissions; the bench plays software and receiver.
module can_message_object_handler_tb_top import cmoh_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WR = 8'hF3;
  localparam logic [7:0] UPD = 8'h87;
  localparam logic [7:0] RDC = 8'h0C;
  localparam logic [7:0] RD = 8'h00;
  logic clock, rst, cmd_req, cm_write, cm_arb, cm_mask, cm_ctrl, cm_clr_irq, cm_fresh;
  logic cm_data_low, cm_data_high, rx_hdr_valid, rx_xtd, rx_rtr, rx_end_ok, hold, fail_next;
  logic tx_ready, tx_ok, tx_fail, tx_load_q, tx_xtd_q, tx_rtr_q, cmd_done_q, busy_q;
  logic [4:0] cmd_obj, tx_obj_q;
  logic [31:0] sw_arb, sw_mask, rd_arb_q, rd_mask_q, irq_pending_q, fresh_q, exp_fresh, exp_irq;
  logic [15:0] sw_ctrl, rd_ctrl_q;
  logic [63:0] sw_data, rd_data_q, rx_data, tx_data_q, d[12];
  logic [28:0] rx_id, tx_id_q;
  logic [3:0] rx_dlc, tx_dlc_q;
  logic [4:0] q_obj[$];
  logic [4:0] e;
  logic [10:0] sid[32];
  logic [63:0] q_dat[$];
  int failures, n_tests;
  // --------------------------------------------------------------
  // Design and far side
  // --------------------------------------------------------------
  cmoh_handler u_dut (.clock, .rst, .cmd_req, .cmd_obj, .cm_write, .cm_arb, .cm_mask, .cm_ctrl,
    .cm_clr_irq, .cm_fresh, .cm_data_low, .cm_data_high, .sw_arb, .sw_mask, .sw_ctrl, .sw_data,
    .rd_arb_q, .rd_mask_q, .rd_ctrl_q, .rd_data_q, .cmd_done_q, .busy_q, .rx_hdr_valid, .rx_id,
    .rx_xtd, .rx_rtr, .rx_dlc, .rx_end_ok, .rx_data, .tx_ready, .tx_ok, .tx_fail, .tx_load_q,
    .tx_obj_q, .tx_id_q, .tx_xtd_q, .tx_rtr_q, .tx_dlc_q, .tx_data_q, .irq_pending_q, .fresh_q);
  cmoh_proto_model u_proto (.clock, .rst, .hold, .fail_next, .tx_load_q, .tx_ready, .tx_ok,
    .tx_fail);
  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic tmo();
    failures++;
    print_verdict();
  endtask : tmo
  // Fields stay put from the request until the done pulse, as the handler latches late.
  task automatic cmd(input logic [4:0] o, input logic [7:0] f, input logic [31:0] a,
                     input logic [15:0] c, input logic [63:0] dd);
    int k;
    {cm_write, cm_arb, cm_mask, cm_ctrl, cm_clr_irq, cm_fresh, cm_data_low, cm_data_high} = f;
    cmd_obj = o;
    sw_arb = a;
    sw_ctrl = c;
    sw_data = dd;
    cmd_req = 1'b1;
    @(posedge clock);
    #1 cmd_req = 1'b0;
    for (k = 0; k < 60 && cmd_done_q !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    if (k == 60) tmo();
    // Lets an edge pass so the next request never meets this one's release.
    @(posedge clock);
    #1;
  endtask : cmd
  // Header, full scan time, then the end of frame; released id, length and data show inverted values.
  task automatic frame(input logic [28:0] id, input logic x, input logic r,
                       input logic [3:0] dl, input logic [63:0] dd);
    rx_id = id;
    rx_xtd = x;
    rx_rtr = r;
    rx_dlc = dl;
    rx_hdr_valid = 1'b1;
    @(posedge clock);
    #1 rx_hdr_valid = 1'b0;
    rx_id = ~id;
    rx_dlc = ~dl;
    cmp(64'(busy_q), 64'h1);
    repeat (CMOH_NUM_OBJ + 2) @(posedge clock);
    #1 rx_end_ok = 1'b1;
    rx_data = dd;
    @(posedge clock);
    #1 rx_end_ok = 1'b0;
    rx_data = ~dd;
    @(posedge clock);
    #1 cmp(64'(busy_q), 64'h0);
  endtask : frame
  task automatic txwait();
    int k;
    for (k = 0; k < 300 && q_obj.size() != 0; k++) @(posedge clock);
    if (k == 300) tmo();
    repeat (12) @(posedge clock);
    #1;
  endtask : txwait
  // Every load is matched against the expected object and data, in order.
  always @(posedge clock) begin
    if (rst === 1'b0 && tx_load_q === 1'b1) begin
      fail_next <= 1'b0;
      if (q_obj.size() == 0) begin
        cmp(64'(tx_obj_q), 64'hFF);
      end else begin
        e = q_obj.pop_front();
        cmp(64'(tx_obj_q), 64'(e));
        cmp(tx_data_q, q_dat.pop_front());
        cmp(64'(tx_id_q), 64'({sid[e], 18'h0}));
        cmp(64'({tx_xtd_q, tx_rtr_q, tx_dlc_q}), 64'h8);
      end
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int k;
    {rst, cmd_req, hold, fail_next} = 4'hA;
    {cm_write, cm_arb, cm_mask, cm_ctrl, cm_clr_irq, cm_fresh, cm_data_low, cm_data_high} = 8'h00;
    {rx_hdr_valid, rx_xtd, rx_rtr, rx_end_ok} = 4'h0;
    {cmd_obj, sw_arb, sw_ctrl, sw_data, rx_id, rx_dlc, rx_data} = '0;
    sw_mask = 32'h1FFFFFFF;
    {failures, n_tests, exp_fresh, exp_irq} = '0;
    void'($urandom(32'h67ED3FD8));
    sid[1] = 11'h123;
    sid[4] = 11'h055;
    sid[7] = 11'h2AA;
    for (k = 0; k < 12; k++) d[k] = {$urandom, $urandom};
    repeat (5) @(posedge clock);
    #1 cmp(64'({fresh_q, irq_pending_q}), 64'h0);
    cmp(64'({tx_load_q, cmd_done_q, busy_q}), 64'h0);
    rst = 1'b0;
    // Objects are set up while the transmitter is held off.
    cmd(5'h01, WR, {3'b101, 11'h123, 18'h0}, 16'h0888, d[1]);
    cmd(5'h04, WR, {3'b101, 11'h055, 18'h0}, 16'h0088, d[4]);
    cmd(5'h07, WR, {3'b101, 11'h2AA, 18'h0}, 16'h0288, d[7]);
    cmd(5'h08, WR, {3'b101, 11'h311, 18'h0}, 16'h0088, d[8]);
    cmd(5'h05, WR, {3'b100, 11'h400, 18'h0}, 16'h0488, d[5]);
    cmd(5'h06, WR, {3'b100, 11'h400, 18'h0}, 16'h0088, d[6]);
    sw_mask = 32'h9FFFFF00;
    cmd(5'h09, WR, {3'b111, 29'h0ABCDEF0}, 16'h1088, d[9]);
    sw_mask = 32'h1FFFFFFF;
    // Two requests, higher number first; the lower one fails once and retries.
    cmd(5'h04, UPD, 32'h0, 16'h0, d[0]);
    cmd(5'h01, UPD, 32'h0, 16'h0, d[2]);
    exp_fresh = 32'h12;
    cmp(64'(fresh_q), 64'(exp_fresh));
    q_obj = {5'h01, 5'h01, 5'h04};
    q_dat = {d[2], d[2], d[0]};
    fail_next = 1'b1;
    hold = 1'b0;
    txwait();
    exp_fresh = 32'h0;
    exp_irq = 32'h2;
    cmp(64'(fresh_q), 64'(exp_fresh));
    cmp(64'(irq_pending_q), 64'(exp_irq));
    cmd(5'h01, RDC, 32'h0, 16'h0, 64'h0);
    cmp(rd_data_q, d[2]);
    cmp(64'(rd_ctrl_q), 64'h2888);
    exp_irq = 32'h0;
    cmp(64'(irq_pending_q), 64'(exp_irq));
    // Renewal while the object is on the bus keeps its request alive.
    hold = 1'b1;
    cmd(5'h04, UPD, 32'h0, 16'h0, d[3]);
    q_obj = {5'h04, 5'h04};
    q_dat = {d[3], d[10]};
    hold = 1'b0;
    for (k = 0; k < 50 && q_obj.size() != 1; k++) @(posedge clock);
    if (k == 50) tmo();
    #1 cmd(5'h04, UPD, 32'h0, 16'h0, d[10]);
    txwait();
    cmp(64'(fresh_q), 64'(exp_fresh));
    // Data frames: lowest matching object takes both, the second overruns.
    k = $urandom_range(32'h3FFFF, 1);
    frame({11'h400, 18'(k)}, 1'b0, 1'b0, 4'h8, d[11]);
    exp_fresh[5] = 1'b1;
    exp_irq[5] = 1'b1;
    cmp(64'(fresh_q), 64'(exp_fresh));
    cmp(64'(irq_pending_q), 64'(exp_irq));
    frame({11'h400, 18'(k)}, 1'b0, 1'b0, 4'h5, d[0]);
    cmd(5'h05, RD, 32'h0, 16'h0, 64'h0);
    cmp(rd_data_q, d[0]);
    cmp(64'(rd_ctrl_q), 64'hE485);
    cmp(64'(rd_arb_q[28:18]), 64'h400);
    cmd(5'h05, RDC, 32'h0, 16'h0, 64'h0);
    exp_fresh[5] = 1'b0;
    exp_irq[5] = 1'b0;
    cmp(64'({fresh_q, irq_pending_q}), 64'({exp_fresh, exp_irq}));
    // Remote frames for the three transmit configurations.
    q_obj = {5'h07};
    q_dat = {d[7]};
    frame({11'h2AA, 18'h0}, 1'b0, 1'b1, 4'h8, d[1]);
    txwait();
    cmd(5'h07, RD, 32'h0, 16'h0, 64'h0);
    cmp(64'(rd_ctrl_q), 64'h0288);
    frame({11'h311, 18'h0}, 1'b0, 1'b1, 4'h8, d[1]);
    frame(29'h0ABCDEF0, 1'b0, 1'b1, 4'h8, d[1]);
    repeat (12) @(posedge clock);
    #1 cmp(64'(fresh_q), 64'(exp_fresh));
    cmd(5'h08, RD, 32'h0, 16'h0, 64'h0);
    cmp(64'(rd_ctrl_q), 64'h0088);
    frame(29'h0ABCDE5A, 1'b1, 1'b1, 4'h3, d[1]);
    exp_fresh[9] = 1'b1;
    cmp(64'(fresh_q), 64'(exp_fresh));
    cmd(5'h09, RD, 32'h0, 16'h0, 64'h0);
    cmp(64'(rd_arb_q[28:0]), 64'h0ABCDE5A);
    cmp(64'(rd_mask_q), 64'h9FFFFF00);
    cmp(rd_data_q, d[9]);
    cmp(64'(rd_ctrl_q & 16'hF10F), 64'h9003);
    print_verdict();
  end
endmodule : can_message_object_handler_tb_top
